// ==== hdl/tmr8_chan.sv ====
// One output compare channel: compare value, match flag and output state.
`timescale 1ns/100ps
`include "tmr8_cfg.svh"
module tmr8_chan
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic [7:0] count,
	input wire logic blocked,
	input wire logic non_pwm,
	input wire logic [1:0] compare_output_mode,
	input wire logic force_compare_strobe,
	input wire logic cmp_wr,
	input wire logic [7:0] wdata,
	input wire logic flag_clr,
	output logic [7:0] compare_value_chan,
	output logic compare_match_flag,
	output logic match_ev,
	output logic compare_output_chan
);
	logic act;
	logic next_ocr;

	assign match_ev = tick && !blocked && (count == compare_value_chan);
	assign act = match_ev || (force_compare_strobe && non_pwm); // [R1]

	always_comb
	begin
		unique case (compare_output_mode) // [R11]
			2'h0: next_ocr = compare_output_chan; // [R8]
			2'h1: next_ocr = !compare_output_chan;
			2'h2: next_ocr = 1'b0;
			2'h3: next_ocr = 1'b1;
		endcase
	end

	// Mode bits are read live, so a new setting acts on the next match.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			compare_output_chan <= `TMR8_OCR_RST; // [R7]
		else if (act)
			compare_output_chan <= next_ocr; // [R2] [R4] [R9]
	end

	// Compare value is written straight through, without buffering.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			compare_value_chan <= `TMR8_CMP_RST;
		else if (cmp_wr)
			compare_value_chan <= wdata; // [R17]
	end

	// A match that lands with a clear keeps the flag set.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			compare_match_flag <= 1'b0;
		else if (match_ev)
			compare_match_flag <= 1'b1; // [R22]
		else if (flag_clr)
			compare_match_flag <= 1'b0; // [R22]
	end

	property p_force_no_flag;
		@(posedge aclk) disable iff (!aresetn)
		force_compare_strobe && !match_ev && !compare_match_flag
			|=> !compare_match_flag;
	endproperty
	a_force_no_flag: assert property (p_force_no_flag) // [R2]
		else $error("forced compare set the match flag");

	property p_force_toggle;
		@(posedge aclk) disable iff (!aresetn)
		force_compare_strobe && non_pwm && compare_output_mode == 2'h1
			|=> compare_output_chan != $past(compare_output_chan);
	endproperty
	a_force_toggle: assert property (p_force_toggle) // [R1]
		else $error("forced compare did not toggle the output");

	property p_mode_zero_holds;
		@(posedge aclk) disable iff (!aresetn)
		compare_output_mode == 2'h0
			|=> $stable(compare_output_chan);
	endproperty
	a_mode_zero_holds: assert property (p_mode_zero_holds) // [R8]
		else $error("output changed with output mode zero");
endmodule

// ==== hdl/tmr8_core.sv ====
// Eight-bit timer with two compare outputs behind an AXI4-Lite slave.
//
// How it works
// R1: Writing a force strobe bit acts as a compare match in non-PWM modes.
// R2: Forced match updates output only; no flag, no counter clear.
// R3: A counter write blocks every compare match on the next timer tick.
// R4: Output mode bits are live and act from the next match.
// R5: Nonzero output mode puts the compare output on the pin.
// R6: Pin override ignores the waveform generation mode.
// R7: Reset clears both compare output states to zero.
// R8: Output mode zero leaves the compare output unchanged on a match.
// R9: Compare outputs keep their value across mode changes.
// R10: Only the waveform mode field shapes the counting sequence.
// R11: Output mode selects set, clear or toggle on a match.
// R12: Mode 0 counts up only and wraps from 0xFF to 0x00.
// R13: Normal mode sets overflow as the counter becomes zero.
// R14: Normal mode takes a counter write at any time.
// R15: Mode 2 clears the counter after a match with compare A.
// R16: In mode 2 flag A is set every period.
// R17: Compare A is unbuffered; a low value wraps through 0xFF first.
// R18: Mode 2 toggle with compare A of zero gives half the clock.
// R19: Mode 2 sets overflow when the counter passes 0xFF to 0x00.
// R20: Software sets the compare output before enabling the pin.
// R21: Software avoids writing the counter equal to a compare value.
// R22: A match sets the channel flag; writing one clears it.
// R23: Clock select zero stops counting; a counter write wins always.
// R24: Force strobes read as zero and hold no state.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "tmr8_cfg.svh"
module tmr8_core
#(
	parameter int CHANNELS = 2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_clk_pin,
	input wire logic [CHANNELS-1:0] port_value,
	input wire logic [CHANNELS-1:0] port_dir,
	output logic [CHANNELS-1:0] pin_out,
	output logic [CHANNELS-1:0] pin_oe_n
);
	tmr8_pkg::tmr8_ctrl_t ctrl;
	tmr8_pkg::tmr8_wr_state_t wr_state;
	tmr8_pkg::tmr8_wgm_t wgm;
	logic [7:0] counter_value;
	logic overflow_flag;
	logic block;
	logic timer_tick;
	logic non_pwm;
	logic [`TMR8_PRE_W-1:0] prescale;
	logic [2:0] ext_sync;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic wr_hit;
	logic cnt_wr;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [CHANNELS-1:0] force_compare_strobe;
	logic [CHANNELS-1:0] cmp_wr;
	logic [CHANNELS-1:0] flag_clr;
	logic [CHANNELS-1:0] match_ev;
	logic [CHANNELS-1:0] compare_match_flag;
	logic [CHANNELS-1:0] compare_output_chan;
	logic [1:0] compare_output_mode [CHANNELS];
	logic [7:0] compare_value_chan [CHANNELS];

	assign wgm = tmr8_pkg::tmr8_wgm_t'(ctrl.waveform_gen_mode);
	assign non_pwm = !ctrl.waveform_gen_mode[0];
	assign compare_output_mode[0] = ctrl.compare_output_mode_a;
	assign compare_output_mode[1] = ctrl.compare_output_mode_b;

	// Clock select: 1..5 internal divide, 6 falling and 7 rising pin edge.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			prescale <= '0;
		else
			prescale <= prescale + `TMR8_PRE_W'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_sync <= 3'h0;
		else
			ext_sync <= {ext_sync[1:0], ext_clk_pin};
	end

	always_comb
	begin
		unique case (ctrl.clock_select_field)
			3'h0: timer_tick = 1'b0; // [R23]
			3'h1: timer_tick = 1'b1;
			3'h2: timer_tick = &prescale[`TMR8_DIV8_W-1:0];
			3'h3: timer_tick = &prescale[`TMR8_DIV64_W-1:0];
			3'h4: timer_tick = &prescale[`TMR8_DIV256_W-1:0];
			3'h5: timer_tick = &prescale[`TMR8_DIV1024_W-1:0];
			3'h6: timer_tick = ext_sync[2] && !ext_sync[1];
			3'h7: timer_tick = !ext_sync[2] && ext_sync[1];
		endcase
	end

	// Write channel: address and data are taken in either order.
	assign s_axi_awready = (wr_state == tmr8_pkg::TMR8_WR_COLLECT) && !aw_held;
	assign s_axi_wready = (wr_state == tmr8_pkg::TMR8_WR_COLLECT) && !w_held;
	assign s_axi_bvalid = (wr_state == tmr8_pkg::TMR8_WR_RESP);
	assign wr_fire = (wr_state == tmr8_pkg::TMR8_WR_COLLECT) && aw_held && w_held;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_held <= 1'b0;
	end

	always_comb
	begin
		unique case (aw_addr)
			`TMR8_OFS_CTRL, `TMR8_OFS_FORCE, `TMR8_OFS_COUNT, `TMR8_OFS_CMPA,
			`TMR8_OFS_CMPB, `TMR8_OFS_FLAGS, `TMR8_OFS_OUT: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state <= tmr8_pkg::TMR8_WR_COLLECT;
			s_axi_bresp <= `TMR8_RESP_OKAY;
		end
		else
		begin
			unique case (wr_state)
				tmr8_pkg::TMR8_WR_COLLECT:
					if (wr_fire)
					begin
						wr_state <= tmr8_pkg::TMR8_WR_RESP;
						s_axi_bresp <= wr_hit ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
					end
				tmr8_pkg::TMR8_WR_RESP:
					if (s_axi_bready)
						wr_state <= tmr8_pkg::TMR8_WR_COLLECT;
				default:
					wr_state <= tmr8_pkg::TMR8_WR_COLLECT;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl <= `TMR8_CTRL_RST;
		else if (wr_fire && aw_addr == `TMR8_OFS_CTRL)
		begin
			if (w_strb[0])
				ctrl[7:0] <= w_data[7:0]; // [R6] [R10]
			if (w_strb[1])
				ctrl[9:8] <= w_data[9:8];
		end
	end

	// Per-lane write strobes into the counter and the channels.
	assign cnt_wr = wr_fire && aw_addr == `TMR8_OFS_COUNT && w_strb[0];
	assign cmp_wr[0] = wr_fire && aw_addr == `TMR8_OFS_CMPA && w_strb[0];
	assign cmp_wr[1] = wr_fire && aw_addr == `TMR8_OFS_CMPB && w_strb[0];

	generate
		for (genvar i = 0; i < CHANNELS; i++)
		begin : g_chan
			assign force_compare_strobe[i] = wr_fire && w_strb[0] &&
				aw_addr == `TMR8_OFS_FORCE && w_data[i]; // [R24]
			assign flag_clr[i] = wr_fire && w_strb[0] &&
				aw_addr == `TMR8_OFS_FLAGS && w_data[`TMR8_FLAG_A+i];
			tmr8_chan u_chan
			(
				.aclk(aclk),
				.aresetn(aresetn),
				.tick(timer_tick),
				.count(counter_value),
				.blocked(block),
				.non_pwm(non_pwm),
				.compare_output_mode(compare_output_mode[i]),
				.force_compare_strobe(force_compare_strobe[i]),
				.cmp_wr(cmp_wr[i]),
				.wdata(w_data[7:0]),
				.flag_clr(flag_clr[i]),
				.compare_value_chan(compare_value_chan[i]),
				.compare_match_flag(compare_match_flag[i]),
				.match_ev(match_ev[i]),
				.compare_output_chan(compare_output_chan[i])
			);
			// Pin shows compare state whenever its mode bits are nonzero.
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					pin_out[i] <= 1'b0;
					pin_oe_n[i] <= 1'b1;
				end
				else
				begin
					pin_out[i] <= (|compare_output_mode[i]) ?
						compare_output_chan[i] : port_value[i]; // [R5] [R6]
					pin_oe_n[i] <= !port_dir[i]; // [R5]
				end
			end
		end
	endgenerate

	// A counter write wins over counting and clearing.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			counter_value <= `TMR8_COUNT_RST;
		else if (cnt_wr)
			counter_value <= w_data[7:0]; // [R14] [R23]
		else if (timer_tick)
		begin
			if (wgm == tmr8_pkg::TMR8_WGM_CLEAR && match_ev[0])
				counter_value <= `TMR8_BOTTOM; // [R15] [R16] [R18]
			else
				counter_value <= counter_value + 8'h01; // [R12] [R17]
		end
	end

	// Matches stay blocked until the tick after a counter write.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			block <= 1'b0;
		else if (cnt_wr)
			block <= 1'b1; // [R3]
		else if (timer_tick)
			block <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			overflow_flag <= 1'b0;
		else if (timer_tick && !cnt_wr && counter_value == `TMR8_MAX)
			overflow_flag <= 1'b1; // [R13] [R19]
		else if (wr_fire && w_strb[0] && aw_addr == `TMR8_OFS_FLAGS &&
			w_data[`TMR8_FLAG_OVF])
			overflow_flag <= 1'b0;
	end

	// Read channel: one read at a time, answered the cycle after it is taken.
	assign s_axi_arready = !s_axi_rvalid;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`TMR8_OFS_CTRL: rd_word[9:0] = ctrl;
			`TMR8_OFS_FORCE: rd_word = 32'h0000_0000; // [R24]
			`TMR8_OFS_COUNT: rd_word[7:0] = counter_value;
			`TMR8_OFS_CMPA: rd_word[7:0] = compare_value_chan[0];
			`TMR8_OFS_CMPB: rd_word[7:0] = compare_value_chan[1];
			`TMR8_OFS_FLAGS: rd_word[2:0] = {compare_match_flag, overflow_flag};
			`TMR8_OFS_OUT: rd_word[1:0] = compare_output_chan;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TMR8_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `TMR8_RESP_OKAY : `TMR8_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_count_write;
		cnt_wr;
	endsequence

	// A tick in the cycle after a counter write, with no new write in it.
	sequence s_next_tick_quiet;
		!cnt_wr && timer_tick;
	endsequence

	property p_block_match;
		s_count_write ##1 s_next_tick_quiet |-> match_ev == '0;
	endproperty
	a_block_match: assert property (p_block_match) // [R3]
		else $error("match not blocked after counter write");

	property p_block_held;
		s_count_write |=> block;
	endproperty
	a_block_held: assert property (p_block_held) // [R3]
		else $error("block not raised after counter write");

	property p_normal_wrap;
		timer_tick && !cnt_wr && wgm == tmr8_pkg::TMR8_WGM_NORMAL &&
			counter_value == `TMR8_MAX
			|=> counter_value == `TMR8_BOTTOM && overflow_flag;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) // [R12]
		else $error("normal mode did not wrap with overflow");

	property p_clear_on_match;
		timer_tick && !cnt_wr && wgm == tmr8_pkg::TMR8_WGM_CLEAR && match_ev[0]
			|=> counter_value == `TMR8_BOTTOM && compare_match_flag[0];
	endproperty
	a_clear_on_match: assert property (p_clear_on_match) // [R15]
		else $error("clear-on-match did not clear counter or set flag");

	property p_stopped;
		ctrl.clock_select_field == 3'h0 && !cnt_wr |=> $stable(counter_value);
	endproperty
	a_stopped: assert property (p_stopped) // [R23]
		else $error("counter moved with clock select zero");

	property p_write_wins;
		cnt_wr |=> counter_value == $past(w_data[7:0]);
	endproperty
	a_write_wins: assert property (p_write_wins) // [R23]
		else $error("counter write did not take priority");

	property p_pin_override;
		compare_output_mode[0] != 2'h0 |=> pin_out[0] == $past(compare_output_chan[0]);
	endproperty
	a_pin_override: assert property (p_pin_override) // [R5]
		else $error("pin not driven from compare output");

	property p_reset_clear;
		@(posedge aclk) disable iff (1'b0)
		!aresetn |=> compare_output_chan == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) // [R7]
		else $error("compare outputs not cleared by reset");
endmodule

// ==== inc/tmr8_cfg.svh ====
// Register offsets, field positions, reset values and divider widths.
`ifndef TMR8_CFG_SVH
`define TMR8_CFG_SVH
`define TMR8_OFS_CTRL 8'h00
`define TMR8_OFS_FORCE 8'h04
`define TMR8_OFS_COUNT 8'h08
`define TMR8_OFS_CMPA 8'h0c
`define TMR8_OFS_CMPB 8'h10
`define TMR8_OFS_FLAGS 8'h14
`define TMR8_OFS_OUT 8'h18
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_A 1
`define TMR8_FLAG_B 2
`define TMR8_CTRL_RST 10'h000
`define TMR8_COUNT_RST 8'h00
`define TMR8_CMP_RST 8'h00
`define TMR8_OCR_RST 1'b0
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`define TMR8_PRE_W 10
`define TMR8_DIV8_W 3
`define TMR8_DIV64_W 6
`define TMR8_DIV256_W 8
`define TMR8_DIV1024_W 10
`define TMR8_RESP_OKAY 2'h0
`define TMR8_RESP_SLVERR 2'h2
`endif

// ==== inc/tmr8_pkg.sv ====
// Types shared by the timer core and its register-level bench.
package tmr8_pkg;
	typedef enum logic [2:0] {
		TMR8_WGM_NORMAL = 3'h0,
		TMR8_WGM_PC_FF = 3'h1,
		TMR8_WGM_CLEAR = 3'h2,
		TMR8_WGM_FAST_FF = 3'h3
	} tmr8_wgm_t;
	typedef struct packed {
		logic [2:0] clock_select_field;
		logic [2:0] waveform_gen_mode;
		logic [1:0] compare_output_mode_b;
		logic [1:0] compare_output_mode_a;
	} tmr8_ctrl_t;
	typedef struct packed {
		logic flag_b;
		logic flag_a;
		logic overflow;
	} tmr8_flags_t;
	typedef enum logic [1:0] {
		TMR8_WR_COLLECT = 2'b01,
		TMR8_WR_RESP = 2'b10
	} tmr8_wr_state_t;
endpackage

// ==== verification/tmr8_core_test.sv ====
// Register-level bench for the timer with its compare outputs.
`timescale 1ns/100ps
`include "tmr8_cfg.svh"
`define CHK(g, e) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("mismatch at %0t: got %h want %h", $time, g, e); \
		end \
	end
module tmr8_core_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0000_0000;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic [1:0] pv = 2'h0;
	logic [1:0] pd = 2'h0;
	logic [1:0] port_value;
	logic [1:0] port_dir;
	logic [1:0] pin_out;
	logic [1:0] pin_oe_n;
	logic [31:0] d;
	logic [1:0] r;
	logic p;
	int n_mismatch = 0;
	int n_tests = 0;

	always #20 aclk = ~aclk;

	tmr8_port_model PORT (.aclk(aclk), .aresetn(aresetn), .set_value(pv),
		.set_dir(pd), .port_value(port_value), .port_dir(port_dir));

	tmr8_core #(.CHANNELS(2)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_clk_pin(1'b0), .port_value(port_value),
		.port_dir(port_dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

	function automatic logic [31:0] ctl(input logic [2:0] cs,
		input logic [2:0] wg, input logic [1:0] ma);
		tmr8_pkg::tmr8_ctrl_t c;
		c = '{cs, wg, 2'h0, ma};
		return {22'h0, c};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(d, e)
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		test_done;
	end

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`TMR8_OFS_OUT, 32'h0000_0000);
		rc(`TMR8_OFS_FORCE, 32'h0000_0000);
		rd(8'h40);
		`CHK(r, `TMR8_RESP_SLVERR)
		wr(8'h40, 32'h0000_0001);
		`CHK(r, `TMR8_RESP_SLVERR)
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h0, 2'h3));
		wr(`TMR8_OFS_FORCE, 32'h0000_0001);
		rc(`TMR8_OFS_OUT, 32'h0000_0001);
		rc(`TMR8_OFS_FLAGS, 32'h0000_0000);
		rc(`TMR8_OFS_COUNT, 32'h0000_0000);
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h0, 2'h2));
		wr(`TMR8_OFS_FORCE, 32'h0000_0001);
		rc(`TMR8_OFS_OUT, 32'h0000_0000);
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h0, 2'h1));
		wr(`TMR8_OFS_FORCE, 32'h0000_0001);
		rc(`TMR8_OFS_OUT, 32'h0000_0001);
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h2, 2'h0));
		wr(`TMR8_OFS_FORCE, 32'h0000_0001);
		rc(`TMR8_OFS_OUT, 32'h0000_0001);
		// Output state is set up first, then the pin is made an output.
		pd <= 2'h3;
		pv <= 2'h2;
		repeat (3) @(posedge aclk);
		`CHK(pin_out[0], 1'b0)
		`CHK(pin_oe_n[0], 1'b0)
		`CHK(pin_out[1], 1'b1)
		`CHK(pin_oe_n[1], 1'b0)
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h2, 2'h1));
		repeat (3) @(posedge aclk);
		`CHK(pin_out[0], 1'b1)
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h0, 2'h0));
		wr(`TMR8_OFS_CMPA, 32'h0000_0010);
		wr(`TMR8_OFS_COUNT, 32'h0000_0010);
		rc(`TMR8_OFS_COUNT, 32'h0000_0010);
		wr(`TMR8_OFS_CTRL, ctl(3'h1, 3'h0, 2'h0));
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h0, 2'h0));
		rc(`TMR8_OFS_FLAGS, 32'h0000_0000);
		wr(`TMR8_OFS_CMPA, 32'h0000_00ff);
		wr(`TMR8_OFS_COUNT, 32'h0000_00fd);
		wr(`TMR8_OFS_CTRL, ctl(3'h1, 3'h0, 2'h0));
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h0, 2'h0));
		rd(`TMR8_OFS_COUNT);
		`CHK(d < 32'h0000_0010, 1'b1)
		rc(`TMR8_OFS_FLAGS, 32'h0000_0007);
		wr(`TMR8_OFS_FLAGS, 32'h0000_0007);
		rc(`TMR8_OFS_FLAGS, 32'h0000_0000);
		wr(`TMR8_OFS_CMPA, 32'h0000_0000);
		wr(`TMR8_OFS_COUNT, 32'h0000_00ff);
		wr(`TMR8_OFS_CTRL, ctl(3'h1, 3'h2, 2'h1));
		repeat (4) @(posedge aclk);
		repeat (6)
		begin
			p = pin_out[0];
			@(posedge aclk);
			`CHK(pin_out[0], ~p)
		end
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h2, 2'h1));
		rc(`TMR8_OFS_COUNT, 32'h0000_0000);
		rd(`TMR8_OFS_FLAGS);
		`CHK(d[`TMR8_FLAG_A], 1'b1)
		wr(`TMR8_OFS_CMPA, 32'h0000_0003);
		wr(`TMR8_OFS_COUNT, 32'h0000_0020);
		wr(`TMR8_OFS_FLAGS, 32'h0000_0007);
		wr(`TMR8_OFS_CTRL, ctl(3'h1, 3'h2, 2'h0));
		repeat (300) @(posedge aclk);
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h2, 2'h0));
		rd(`TMR8_OFS_COUNT);
		`CHK(d < 32'h0000_0004, 1'b1)
		rd(`TMR8_OFS_FLAGS);
		`CHK(d[`TMR8_FLAG_OVF], 1'b1)
		wr(`TMR8_OFS_CMPA, 32'h0000_0080);
		wr(`TMR8_OFS_FLAGS, 32'h0000_0007);
		wr(`TMR8_OFS_CTRL, ctl(3'h1, 3'h0, 2'h0));
		// A running counter is loaded with the compare value on purpose.
		wr(`TMR8_OFS_COUNT, 32'h0000_0080);
		wr(`TMR8_OFS_CTRL, ctl(3'h0, 3'h0, 2'h0));
		rd(`TMR8_OFS_FLAGS);
		`CHK(d[`TMR8_FLAG_A], 1'b0)
		test_done;
	end
endmodule

// ==== verification/tmr8_port_model.sv ====
// Port pin logic that feeds the normal output value and direction.
`timescale 1ns/100ps
module tmr8_port_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] set_value,
	input wire logic [1:0] set_dir,
	output logic [1:0] port_value,
	output logic [1:0] port_dir
);
	// Pins come out of reset as inputs, so nothing is driven too early.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_value <= 2'h0;
			port_dir <= 2'h0;
		end
		else
		begin
			port_value <= set_value;
			port_dir <= set_dir;
		end
	end
endmodule
